// *** hw/stp_scan_fanout.sv ***
`timescale 1ns/1ps
module stp_scan_fanout
  import stp_pkg::*;
(
  // System clock and register port
  input wire logic clk,
  input wire logic reset,
  input wire logic [STP_ADDR_W-1:0] reg_addr,
  input wire logic [STP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [STP_DATA_W-1:0] reg_rdata,
  // Backplane test clock, selected master clock
  input wire logic test_clk,
  // Two-way ports A and B
  input wire stp_bidir_in_s side_a_in,
  output stp_bidir_out_s side_a_out,
  output logic side_a_oe_n,
  input wire stp_bidir_in_s side_b_in,
  output stp_bidir_out_s side_b_out,
  output logic side_b_oe_n,
  // Straps and enables
  input wire logic master_port_select,
  input wire logic [STP_SLOT_W-1:0] slot_id,
  input wire logic local_oe_n,
  // Local chain ports 1 to 6
  output logic [6:1] lcl_tdo,
  input wire logic [6:1] lcl_tdi,
  output logic [6:1] lcl_tms,
  output logic [6:1] lcl_tck,
  output logic [6:1] lcl_trst_n,
  output logic [6:1] lcl_oe_n,
  // Local chain port 1 pass-through
  input wire logic [1:0] lcl1_passthru_in,
  output logic [1:0] lcl1_passthru_out,
  // Local tri-state notification
  output logic [STP_NOTIFY-1:0] local_hiz_notify
);

  // System domain
  stp_cfg_s cfg;
  logic [STP_DATA_W-1:0] next_rdata;
  logic mps_s1, mps_s2, mps_q;
  logic [STP_SLOT_W-1:0] slot_s1, slot_s2;
  logic [2:0] st_s1, st_s2;

  // Test clock domain
  logic bp_trst_n;
  stp_cfg_s cfg_s1, cfg_s2;
  logic mps_t1, mps_t;
  logic oe_s1, oe_s2, lhiz;
  logic [5:0] pt_s1, pt_s2;
  logic [6:0] tdo_q, tms_q, next_tdo, next_tms;
  logic bp_tdo_q, next_bp_tdo, bp_hiz_q;
  logic [1:0] bp_pt_q, lpt0_q, lpt1_q;
  logic [1:0] next_bp_pt, next_lpt0, next_lpt1;
  stp_bidir_in_s bp_in, l0_in;
  stp_bidir_out_s bp_out, l0_out;
  wire single = stp_is_single(cfg_s2.sel);
  wire next_bp_hiz = cfg_s2.bp_hiz | (cfg_s2.sel == 7'h00);
  wire [6:0] lcl_tdi_all = {lcl_tdi, l0_in.tdi};
  // Gate read from the control flops, so a held reset keeps its gating
  wire [6:0] lcl_trst_all = {7{bp_trst_n}} | ~cfg.gate;
  wire [1:0] bp_pt_sync = pt_s2[1:0];
  wire [1:0] l0_pt_sync = pt_s2[3:2];
  wire [1:0] l1_pt_sync = pt_s2[5:4];

  // Register decode
  wire ctrl_hit = reg_addr == STP_ADDR_CTRL;
  wire status_hit = reg_addr == STP_ADDR_STATUS;
  wire slot_hit = reg_addr == STP_ADDR_SLOT;
  wire [STP_DATA_W-1:0] ctrl_rd = {15'h0000, cfg.bp_hiz, 1'b0, cfg.gate,
    1'b0, cfg.sel};
  wire [STP_DATA_W-1:0] status_rd = {28'h0000000, st_s2[2], mps_q, st_s2[1],
    st_s2[0]};
  wire [STP_DATA_W-1:0] slot_rd = {24'h000000, slot_s2};
  assign next_rdata = !reg_rd ? '0 : ctrl_hit ? ctrl_rd :
    status_hit ? status_rd : slot_hit ? slot_rd : '0;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg <= STP_CFG_RST;
      reg_rdata <= '0;
    end
    else
    begin
      if (reg_wr && ctrl_hit)
      begin
        cfg.sel <= reg_wdata[STP_CTRL_SEL_LSB +: 7];
        cfg.gate <= reg_wdata[STP_CTRL_GATE_LSB +: 7];
        cfg.bp_hiz <= reg_wdata[STP_CTRL_BPHIZ_BIT];
      end
      reg_rdata <= next_rdata;
    end
  end

  // Strap and status synchronisers into the system domain
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mps_s1 <= 1'b0;
      mps_s2 <= 1'b0;
      mps_q <= 1'b0;
      slot_s1 <= '0;
      slot_s2 <= '0;
      st_s1 <= '0;
      st_s2 <= '0;
    end
    else
    begin
      mps_s1 <= master_port_select;
      mps_s2 <= mps_s1;
      mps_q <= mps_s2;
      slot_s1 <= slot_id;
      slot_s2 <= slot_s1;
      st_s1 <= {bp_hiz_q, lhiz, single};
      st_s2 <= st_s1;
    end
  end

  // Master reset taken from whichever port is the backplane
  assign bp_trst_n = mps_q ? side_b_in.trst_n : side_a_in.trst_n;
  assign bp_in = mps_t ? side_b_in : side_a_in;
  assign l0_in = mps_t ? side_a_in : side_b_in;

  // Serial chain through the selected ports in ascending order
  always_comb
  begin
    logic src;
    src = bp_in.tdi;
    for (int p = 0; p < STP_PORTS; p++)
    begin
      next_tdo[p] = cfg_s2.sel[p] ? src : 1'b0;
      next_tms[p] = cfg_s2.sel[p] ? bp_in.tms : tms_q[p];
      if (cfg_s2.sel[p])
        src = lcl_tdi_all[p];
    end
    next_bp_tdo = src;
  end

  // Pass-through only with exactly one port 0 or 1 selected
  assign next_lpt0 = (single && cfg_s2.sel[0]) ? bp_pt_sync : 2'h0;
  assign next_lpt1 = (single && cfg_s2.sel[1]) ? bp_pt_sync : 2'h0;
  assign next_bp_pt = !single ? 2'h0 : cfg_s2.sel[0] ? l0_pt_sync :
    cfg_s2.sel[1] ? l1_pt_sync : 2'h0;

  // Link logic, reset by the backplane test reset
  always_ff @(posedge test_clk or negedge bp_trst_n)
  begin
    if (!bp_trst_n)
    begin
      cfg_s1 <= STP_CFG_RST;
      cfg_s2 <= STP_CFG_RST;
      mps_t1 <= 1'b0;
      mps_t <= 1'b0;
      oe_s1 <= 1'b1;
      oe_s2 <= 1'b1;
      lhiz <= 1'b1;
      pt_s1 <= '0;
      pt_s2 <= '0;
    end
    else
    begin
      cfg_s1 <= cfg;
      cfg_s2 <= cfg_s1;
      mps_t1 <= mps_q;
      mps_t <= mps_t1;
      oe_s1 <= local_oe_n;
      oe_s2 <= oe_s1;
      lhiz <= oe_s2;
      pt_s1 <= {lcl1_passthru_in, l0_in.passthru_in, bp_in.passthru_in};
      pt_s2 <= pt_s1;
    end
  end

  always_ff @(posedge test_clk or negedge bp_trst_n)
  begin
    if (!bp_trst_n)
    begin
      tdo_q <= '0;
      tms_q <= '1;
      bp_tdo_q <= 1'b0;
      bp_hiz_q <= 1'b1;
      bp_pt_q <= '0;
      lpt0_q <= '0;
      lpt1_q <= '0;
    end
    else
    begin
      tdo_q <= next_tdo;
      tms_q <= next_tms;
      bp_tdo_q <= next_bp_tdo;
      bp_hiz_q <= next_bp_hiz;
      bp_pt_q <= next_bp_pt;
      lpt0_q <= next_lpt0;
      lpt1_q <= next_lpt1;
    end
  end

  // Port assembly
  assign bp_out = '{tck: 1'b0, tms: 1'b0, tdo: bp_tdo_q, trst_n: 1'b1,
    passthru_out: bp_pt_q, hiz_notify: bp_hiz_q};
  assign l0_out = '{tck: test_clk, tms: tms_q[0], tdo: tdo_q[0],
    trst_n: lcl_trst_all[0], passthru_out: lpt0_q, hiz_notify: lhiz};
  assign side_a_out = mps_t ? l0_out : bp_out;
  assign side_b_out = mps_t ? bp_out : l0_out;
  assign side_a_oe_n = mps_t ? lhiz : bp_hiz_q;
  assign side_b_oe_n = mps_t ? bp_hiz_q : lhiz;
  assign lcl_tdo = tdo_q[6:1];
  assign lcl_tms = tms_q[6:1];
  assign lcl_tck = {6{test_clk}};
  assign lcl_trst_n = lcl_trst_all[6:1];
  assign lcl_oe_n = {6{lhiz}};
  assign lcl1_passthru_out = lpt1_q;
  assign local_hiz_notify = {STP_NOTIFY{lhiz}};

  // Checks
  sequence oe_held_s;
    local_oe_n [*3];
  endsequence

  sequence lcl_off_s;
    lhiz && (&lcl_oe_n) && (&local_hiz_notify);
  endsequence

  bp_notify_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    ##1 (bp_hiz_q == $past(next_bp_hiz)) &&
    ((mps_t ? side_b_oe_n : side_a_oe_n) == bp_out.hiz_notify))
    else $error("backplane notify disagrees with tri-state");

  fwd_in_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    (single && cfg_s2.sel[0]) |=> (lpt0_q == $past(bp_pt_sync)))
    else $error("backplane pass-through not forwarded");

  ret_path_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    (single && cfg_s2.sel[1]) |=> (bp_pt_q == $past(l1_pt_sync)) &&
    (lcl1_passthru_out == $past(bp_pt_sync)))
    else $error("local pass-through not returned");

  multi_block_a: assert property (@(posedge test_clk)
    disable iff (!bp_trst_n)
    !single |=> (bp_pt_q == 2'h0) && (lpt0_q == 2'h0) && (lpt1_q == 2'h0))
    else $error("pass-through active with several ports");

  lcl_hiz_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    oe_held_s |-> ##[1:3] lcl_off_s)
    else $error("local ports not tri-stated");

  notify_rise_a: assert property (@(posedge test_clk)
    disable iff (!bp_trst_n)
    $rose(lhiz) |-> lcl_off_s ##1 (local_hiz_notify == {STP_NOTIFY{lhiz}}))
    else $error("local notify wrong");

  trst_gate_a: assert property (@(posedge test_clk)
    (!bp_trst_n && !cfg.gate[1] && cfg.gate[2]) |->
    lcl_trst_n[1] && !lcl_trst_n[2])
    else $error("gated reset leaked");

  scan_data_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    (cfg_s2.sel == 7'h04) |=> (tdo_q[2] == $past(bp_in.tdi)) &&
    (bp_tdo_q == $past(lcl_tdi[2])) && (lcl_tms[2] == $past(bp_in.tms)) &&
    (tdo_q[3] == 1'b0))
    else $error("scan data path wrong");

  swap_a: assert property (@(posedge test_clk) disable iff (!bp_trst_n)
    mps_t |-> (side_a_oe_n == lhiz) && (side_b_oe_n == bp_hiz_q) &&
    (side_b_out.tdo == bp_tdo_q) && (side_a_out.tck == test_clk))
    else $error("master port swap wrong");

endmodule

// *** pkg/stp_pkg.sv ***
package stp_pkg;
  localparam int STP_PORTS = 7;
  localparam int STP_NOTIFY = 3;
  localparam int STP_SLOT_W = 8;
  localparam int STP_DATA_W = 32;
  localparam int STP_ADDR_W = 4;

  // Register byte offsets
  localparam logic [3:0] STP_ADDR_CTRL = 4'h0;
  localparam logic [3:0] STP_ADDR_STATUS = 4'h4;
  localparam logic [3:0] STP_ADDR_SLOT = 4'h8;

  // Control register fields
  localparam int STP_CTRL_SEL_LSB = 0;
  localparam int STP_CTRL_GATE_LSB = 8;
  localparam int STP_CTRL_BPHIZ_BIT = 16;
  localparam logic [6:0] STP_SEL_RST = 7'h00;
  localparam logic [6:0] STP_GATE_RST = 7'h7f;
  localparam logic STP_BPHIZ_RST = 1'b1;

  // Status register fields
  localparam int STP_ST_SINGLE_BIT = 0;
  localparam int STP_ST_LHIZ_BIT = 1;
  localparam int STP_ST_MPS_BIT = 2;
  localparam int STP_ST_BPHIZ_BIT = 3;

  // Pins of a two-way port seen as inputs
  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_n;
    logic [1:0] passthru_in;
  } stp_bidir_in_s;

  // Pins of a two-way port seen as outputs
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdo;
    logic trst_n;
    logic [1:0] passthru_out;
    logic hiz_notify;
  } stp_bidir_out_s;

  typedef struct packed {
    logic [6:0] sel;
    logic [6:0] gate;
    logic bp_hiz;
  } stp_cfg_s;

  localparam stp_cfg_s STP_CFG_RST = '{sel: STP_SEL_RST, gate: STP_GATE_RST,
    bp_hiz: STP_BPHIZ_RST};

  function automatic logic stp_is_single(input logic [6:0] sel);
    return (sel != 7'h00) && ((sel & (sel - 7'h01)) == 7'h00);
  endfunction
endpackage

// *** testbench/stp_chain_model.sv ***
`timescale 1ns/1ps
module stp_chain_model
  import stp_pkg::*;
(
  // Backplane master clock
  output logic test_clk,
  // Local chains
  input wire logic [6:1] lcl_tck,
  input wire logic [6:1] lcl_tdo,
  input wire logic [6:1] lcl_oe_n,
  output logic [6:1] lcl_tdi
);
  initial
  begin
    test_clk = 1'b0;
    lcl_tdi = 6'h3f;
    #7;
    forever #15 test_clk = ~test_clk;
  end
  // One-bit chain per port; released pins float to the pull-up
  for (genvar p = 1; p <= 6; p++)
  begin : g_chain
    always @(negedge lcl_tck[p] or posedge lcl_oe_n[p])
      lcl_tdi[p] <= lcl_oe_n[p] ? 1'b1 : lcl_tdo[p];
  end
endmodule

// *** testbench/stp_scan_fanout_tb_top.sv ***
`timescale 1ns/1ps
module stp_scan_fanout_tb_top;
  import stp_pkg::*;
  logic clk, reset, wr_s, rd_s, loe, test_clk, rd_d, chk, mps;
  logic [3:0] addr;
  logic [31:0] wd, rdata;
  stp_bidir_in_s a_in, b_in;
  stp_bidir_out_s a_out, b_out;
  logic a_oe_n, b_oe_n;
  logic [7:0] slot;
  logic [6:1] tdo, tdi, tms, tck, trst_n, loe_n;
  logic [1:0] p1_in, p1_out, pt;
  logic [2:0] notify;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int error_cnt, tests_run, chk_id;

  stp_scan_fanout stp_scan_fanout_inst (.clk(clk), .reset(reset),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdata), .test_clk(test_clk), .side_a_in(a_in),
    .side_a_out(a_out), .side_a_oe_n(a_oe_n), .side_b_in(b_in),
    .side_b_out(b_out), .side_b_oe_n(b_oe_n), .master_port_select(mps),
    .slot_id(slot), .local_oe_n(loe), .lcl_tdo(tdo), .lcl_tdi(tdi),
    .lcl_tms(tms), .lcl_tck(tck), .lcl_trst_n(trst_n), .lcl_oe_n(loe_n),
    .lcl1_passthru_in(p1_in), .lcl1_passthru_out(p1_out),
    .local_hiz_notify(notify));
  stp_chain_model stp_chain_model_inst (.test_clk(test_clk),
    .lcl_tck(tck), .lcl_tdo(tdo), .lcl_oe_n(loe_n), .lcl_tdi(tdi));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] pick(input int id);
    case (id)
      0: return 32'(a_out.passthru_out);
      1: return 32'(b_out.passthru_out);
      2: return 32'(p1_out);
      3: return {30'h0, a_out.hiz_notify, a_oe_n};
      4: return {23'h0, notify, loe_n};
      5: return 32'(trst_n);
      6: return 32'(tdo);
      7: return 32'(tck ^ {6{test_clk}});
      default: return 32'(a_out.tdo);
    endcase
  endfunction

  task automatic cmp_reg(input logic [31:0] seen);
    logic [31:0] e;
    string n;
    e = exp_q.pop_front();
    n = nm_q.pop_front();
    tests_run++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, seen);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] seen);
    cmp_reg(seen);
  endtask

  // Watches outputs and retires the oldest expectation
  always @(posedge clk)
  begin
    if (rd_d)
      cmp_reg(rdata);
    if (chk)
      cmp_pin(pick(chk_id));
    rd_d <= rd_s;
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pin(input int id, input logic [31:0] e, string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    chk_id <= id;
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    @(posedge clk);
  endtask

  // Covers 2-edge config sync plus 3-edge pin path at 30 ns
  task automatic settle();
    repeat (80) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #60000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    reset = 1'b1;
    {wr_s, rd_s, rd_d, chk, chk_id, addr, wd, p1_in} = '0;
    a_in = '{tms: 1'b1, tdi: 1'b0, trst_n: 1'b0, passthru_in: 2'h0};
    b_in = '{tms: 1'b1, tdi: 1'b0, trst_n: 1'b1, passthru_in: 2'h0};
    loe = 1'b1;
    mps = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(46014));
    slot = 8'($urandom);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    pin(5, 32'h0, "lcl_trst_n");
    a_in.trst_n <= 1'b1;
    @(posedge clk);
    rd(STP_ADDR_CTRL, 32'h0001_7f00, "ctrl");
    rd(STP_ADDR_SLOT, {24'h0, slot}, "slot");
    rd(4'hc, 32'h0, "unmapped");
    settle();
    pin(4, 32'h1ff, "local_hiz");
    pin(3, 32'h3, "bp_hiz");
    loe <= 1'b0;
    wr(STP_ADDR_CTRL, 32'h7f01);
    settle();
    pin(4, 32'h0, "local_hiz");
    pin(3, 32'h0, "bp_hiz");
    rd(STP_ADDR_STATUS, 32'h1, "status");
    for (int s = 1; s < 4; s++)
    begin
      pt = 2'($urandom);
      a_in.passthru_in <= pt;
      b_in.passthru_in <= ~pt;
      p1_in <= pt ^ 2'h1;
      wr(STP_ADDR_CTRL, 32'h7f00 | s);
      settle();
      pin(1, s == 1 ? pt : 0, "p0_out");
      pin(2, s == 2 ? pt : 0, "p1_out");
      pin(0, s == 1 ? {30'h0, ~pt} : s == 2 ? {30'h0, pt ^ 2'h1} : 32'h0,
        "bp_out");
    end
    a_in.tdi <= 1'b1;
    wr(STP_ADDR_CTRL, 32'h7f04);
    settle();
    pin(6, 32'h2, "lcl_tdo");
    pin(8, 32'h1, "bp_tdo");
    pin(7, 32'h0, "lcl_tck");
    repeat (3) @(posedge clk);
    pin(7, 32'h0, "lcl_tck");
    wr(STP_ADDR_CTRL, 32'h7d04);
    a_in.trst_n <= 1'b0;
    pin(4, 32'h1ff, "trst_hiz");
    pin(5, 32'h1, "lcl_trst_n");
    repeat (10) @(posedge clk);
    mps <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    wr(STP_ADDR_CTRL, 32'h7f01);
    settle();
    pin(3, 32'h0, "l0_hiz");
    pin(1, {30'h0, a_in.passthru_in}, "bp_out_swap");
    rd(STP_ADDR_STATUS, 32'h5, "status_swap");
    complete_run();
  end
endmodule
